// ==== lmcd_pkg.sv ====
// constants and types shared by the motion command decoder
package lmcd_pkg;
    // apb register byte offsets
    localparam logic [7:0]  LMCD_CTRL_OFS    = 8'h00;
    localparam logic [7:0]  LMCD_IDS_OFS     = 8'h04;
    localparam logic [7:0]  LMCD_SECURE_POSITION_OFS  = 8'h08;
    localparam logic [7:0]  LMCD_STATUS_OFS  = 8'h0C;
    localparam logic [7:0]  LMCD_PARAM_OFS   = 8'h10;
    // control register fields
    localparam int          LMCD_CTRL_PERMIT = 0;
    localparam int          LMCD_CTRL_STEP   = 1;
    localparam int          LMCD_CTRL_ADDR   = 8;
    // identifier register fields
    localparam int          LMCD_IDS_SHORT   = 0;
    localparam int          LMCD_IDS_PARAM   = 8;
    localparam int          LMCD_IDS_GP2     = 16;
    // status register fields
    localparam int          LMCD_ST_BEMF     = 16;
    localparam int          LMCD_ST_SLEEP    = 17;
    localparam int          LMCD_ST_STOPPED  = 18;
    localparam int          LMCD_ST_DECEL    = 19;
    localparam int          LMCD_ST_SWITCH   = 20;
    // reset values
    localparam logic [31:0] LMCD_CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] LMCD_IDS_RST     = 32'h0000_0000;
    localparam logic [10:0] LMCD_SECURE_POSITION_DIS  = 11'h400;
    // frame codes
    localparam logic [7:0]  LMCD_SLEEP_PID   = 8'h3C;
    localparam logic [7:0]  LMCD_SLEEP_D1    = 8'h00;
    localparam logic [7:0]  LMCD_FILL_BYTE   = 8'hFF;
    localparam logic [6:0]  LMCD_CMD_STOP    = 7'h0F;
    localparam logic [6:0]  LMCD_CMD_BEMF    = 7'h1F;
    localparam logic [1:0]  LMCD_ID_SHORT_HI = 2'h3;
    localparam logic [1:0]  LMCD_ID_PARAM_HI = 2'h2;
    localparam logic [1:0]  LMCD_STEP_HALF   = 2'h0;
    localparam logic [3:0]  LMCD_LEN_SHORT   = 4'h8;
    localparam logic [3:0]  LMCD_LEN_PARAM   = 4'h4;
    localparam logic [3:0]  LMCD_LEN_GP2     = 4'h2;
    localparam logic [3:0]  LMCD_LEN_SLEEP   = 4'h8;

    typedef enum logic [2:0] {
        LMCD_RUN,
        LMCD_DECEL,
        LMCD_SLEEP_WAIT,
        LMCD_SLEEP,
        LMCD_STOPPED
    } lmcd_state_t;
endpackage : lmcd_pkg

// ==== lmcd_sync.sv ====
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module lmcd_sync
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule : lmcd_sync

// ==== lmcd_entry.sv ====
// one motor entry of the eight-byte short positioning frame
`timescale 1ns/1ps
module lmcd_entry
(
    input  wire logic [7:0]  byte_hi,
    input  wire logic [7:0]  byte_lo,
    input  wire logic [3:0]  own_addr,
    output logic             hit,
    output logic [15:0]      position
);
    // bit 4 must read as one, low nibble is the address
    assign hit      = byte_hi[4] && (byte_hi[3:0] == own_addr);
    // eleven-bit signed set-point widened to the target width
    assign position = {{5{byte_hi[7]}}, byte_hi[7:5], byte_lo};
endmodule : lmcd_entry

// ==== lmcd_decoder.sv ====
// motion command decoder for LIN write frames with an apb register file
//
// Overview of operation
// - Eight-byte short frame: four entries, position 10:8 on top, one at bit 4, address.
// - Short frame recognised only by its allocated identifier, bits 5 and 4 both one.
// - Short entry position is signed eleven bits, loaded as target when addressed.
// - Each entry address compared with own four low address bits.
// - Parameter frame: position bytes 1-2, velocity nibbles byte 3, threshold/accel byte 4.
// - Parameter frame position is a signed sixteen-bit absolute set-point.
// - Sleep is identifier 0x3C, first byte 0x00, rest 0xFF, for every node.
// - Sleep while moving: target takes secure position unless disabled, else decelerating stop.
// - Sleep only with sleep permit set, otherwise stopped state.
// - Decelerating stop during motion slows to minimum velocity then halts.
// - After the halt the target is overwritten with the actual position.
// - Decelerating stop command ignored during a two-stage reference run.
// - Thermal shutdown going active triggers a decelerating stop internally.
// - Stop frame: byte 1 bit 7 set plus code, byte 2 broadcast and address.
// - Stop with broadcast flag zero acts on every node.
// - Stop and back-emf use the general two-byte identifier, decoded from the code.
// - Back-emf command routes integrator output onto the switch-input pin.
// - Back-emf observation stays active until power-on reset.
// - Switch-input sampling suppressed while back-emf observation is active.
// - Back-emf with broadcast flag zero acts on every node.
// - Short frames only act in half-step resolution.
// - Short entry address matched against low four physical address bits.
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
module lmcd_decoder
    import lmcd_pkg::*;
#(
    parameter int ENTRIES = 4
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        frm_valid,
    input  wire logic [7:0]  frm_pid,
    input  wire logic [3:0]  frm_len,
    input  wire logic [63:0] frm_data,
    input  wire logic        frm_csum_ok,
    input  wire logic        motor_moving,
    input  wire logic [15:0] actual_position,
    input  wire logic        two_stage_reference_run,
    input  wire logic        thermal_shutdown,
    input  wire logic        bemf_integrator,
    input  wire logic        switch_input_pin_i,
    output logic             switch_input_pin_o,
    output logic             switch_input_pin_oe,
    output logic [15:0]      target_position,
    output logic             target_load,
    output logic [3:0]       max_velocity,
    output logic [3:0]       min_velocity,
    output logic [3:0]       absolute_threshold,
    output logic [3:0]       acceleration,
    output logic             decel_stop,
    output logic             sleep_mode,
    output logic             stopped_state,
    output logic             bemf_active,
    output logic             switch_state
);
    logic [31:0]        ctrl_reg;
    logic [31:0]        ids_reg;
    logic [10:0]        secure_position;
    logic               sleep_permit;
    logic [1:0]         step_resolution;
    logic [6:0]         node_address;
    logic [3:0]         physical_address_bits;
    logic [5:0]         short_id;
    logic [5:0]         param_id;
    logic [5:0]         gp2_id;
    lmcd_state_t        state;
    lmcd_state_t        next_state;
    lmcd_state_t        sleep_goal;
    logic               sleep_after;
    logic [7:0]         d [1:8];
    logic [5:0]         fid;
    logic               parity_ok;
    logic               frame_take;
    logic               short_hit;
    logic               param_hit;
    logic               gp2_hit;
    logic               addr_ok;
    logic               cmd_stop;
    logic               cmd_bemf;
    logic               cmd_sleep;
    logic               therm_sync;
    logic               therm_prev;
    logic               therm_rise;
    logic               stop_trig;
    logic               swi_sync;
    logic               secure_position_on;
    logic               accept_pos;
    logic               halt_done;
    logic [ENTRIES-1:0] ent_hit;
    logic [15:0]        ent_pos [ENTRIES];
    logic               short_any;
    logic [15:0]        next_short_pos;
    logic               apb_wr;
    logic               apb_map;

    assign sleep_permit          = ctrl_reg[LMCD_CTRL_PERMIT];
    assign step_resolution       = ctrl_reg[LMCD_CTRL_STEP +: 2];
    assign node_address          = ctrl_reg[LMCD_CTRL_ADDR +: 7];
    assign physical_address_bits = node_address[3:0];
    assign short_id              = ids_reg[LMCD_IDS_SHORT +: 6];
    assign param_id              = ids_reg[LMCD_IDS_PARAM +: 6];
    assign gp2_id                = ids_reg[LMCD_IDS_GP2 +: 6];

    // frame bytes, data byte n sits in bits 8n-1 down to 8n-8
    always_comb
    begin
        for (int i = 1; i <= 8; i++)
            d[i] = frm_data[8*i-1 -: 8];
    end

    assign fid       = frm_pid[5:0];
    assign parity_ok = (frm_pid[6] == (fid[0] ^ fid[1] ^ fid[2] ^ fid[4]))
                    && (frm_pid[7] == ~(fid[1] ^ fid[3] ^ fid[4] ^ fid[5]));
    assign frame_take = frm_valid && frm_csum_ok && parity_ok;

    assign short_hit = frame_take && (fid == short_id) && (fid[5:4] == LMCD_ID_SHORT_HI)
                    && (frm_len == LMCD_LEN_SHORT)
                    && (step_resolution == LMCD_STEP_HALF);
    assign param_hit = frame_take && (fid == param_id) && (fid[5:4] == LMCD_ID_PARAM_HI)
                    && (frm_len == LMCD_LEN_PARAM);
    assign gp2_hit   = frame_take && (fid == gp2_id) && (frm_len == LMCD_LEN_GP2)
                    && d[1][7];
    assign addr_ok   = !d[2][7] || (d[2][6:0] == node_address);
    // a reference run in progress swallows a requested stop
    assign cmd_stop  = gp2_hit && (d[1][6:0] == LMCD_CMD_STOP) && addr_ok
                    && !two_stage_reference_run;
    assign cmd_bemf  = gp2_hit && (d[1][6:0] == LMCD_CMD_BEMF) && addr_ok;
    // sleep is for every node, no address check
    assign cmd_sleep = frame_take && (frm_pid == LMCD_SLEEP_PID)
                    && (frm_len == LMCD_LEN_SLEEP) && (d[1] == LMCD_SLEEP_D1)
                    && (frm_data[63:8] == {7{LMCD_FILL_BYTE}});

    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++)
        begin : g_entry
            lmcd_entry u_entry
            (
                .byte_hi  (frm_data[16*g+7 -: 8]),
                .byte_lo  (frm_data[16*g+15 -: 8]),
                .own_addr (physical_address_bits),
                .hit      (ent_hit[g]),
                .position (ent_pos[g])
            );
        end
    endgenerate

    // several entries for one node: the first in the frame wins
    always_comb
    begin
        short_any      = 1'b0;
        next_short_pos = 16'h0000;
        for (int i = ENTRIES - 1; i >= 0; i--)
        begin
            if (ent_hit[i])
            begin
                short_any      = 1'b1;
                next_short_pos = ent_pos[i];
            end
        end
    end

    lmcd_sync u_therm_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (thermal_shutdown),
        .sync_out (therm_sync)
    );

    lmcd_sync u_swi_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (switch_input_pin_i),
        .sync_out (swi_sync)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            therm_prev <= 1'b0;
        else
            therm_prev <= therm_sync;
    end

    assign therm_rise = therm_sync && !therm_prev;
    assign stop_trig  = cmd_stop || therm_rise;
    assign secure_position_on  = (secure_position != LMCD_SECURE_POSITION_DIS);
    assign sleep_goal = sleep_permit ? LMCD_SLEEP : LMCD_STOPPED;
    assign accept_pos = (state == LMCD_RUN) || (state == LMCD_SLEEP)
                     || (state == LMCD_STOPPED);
    assign halt_done  = (state == LMCD_DECEL) && !motor_moving;

    always_comb
    begin
        next_state = state;
        case (state)
            LMCD_RUN:
            begin
                if (cmd_sleep && motor_moving)
                    next_state = secure_position_on ? LMCD_SLEEP_WAIT : LMCD_DECEL;
                else if (cmd_sleep)
                    next_state = sleep_goal;
                else if (stop_trig && motor_moving)
                    next_state = LMCD_DECEL;
            end
            LMCD_DECEL:
                if (!motor_moving)
                    next_state = sleep_after ? sleep_goal : LMCD_RUN;
            LMCD_SLEEP_WAIT:
                if (!motor_moving)
                    next_state = sleep_goal;
            LMCD_SLEEP, LMCD_STOPPED:
                if ((short_hit && short_any) || param_hit)
                    next_state = LMCD_RUN;
            default:
                next_state = LMCD_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= LMCD_RUN;
        else
            state <= next_state;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sleep_after <= 1'b0;
        else if (state == LMCD_RUN)
            sleep_after <= cmd_sleep;
    end

    // the halt overwrite wins over any frame in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            target_position <= 16'h0000;
            target_load     <= 1'b0;
        end
        else if (halt_done)
        begin
            target_position <= actual_position;
            target_load     <= 1'b1;
        end
        else if ((state == LMCD_RUN) && cmd_sleep && motor_moving && secure_position_on)
        begin
            target_position <= {{5{secure_position[10]}}, secure_position};
            target_load     <= 1'b1;
        end
        else if (accept_pos && short_hit && short_any)
        begin
            target_position <= next_short_pos;
            target_load     <= 1'b1;
        end
        else if (accept_pos && param_hit)
        begin
            target_position <= {d[1], d[2]};
            target_load     <= 1'b1;
        end
        else
            target_load     <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            max_velocity       <= 4'h0;
            min_velocity       <= 4'h0;
            absolute_threshold <= 4'h0;
            acceleration       <= 4'h0;
        end
        else if (accept_pos && param_hit)
        begin
            max_velocity       <= d[3][7:4];
            min_velocity       <= d[3][3:0];
            absolute_threshold <= d[4][7:4];
            acceleration       <= d[4][3:0];
        end
    end

    assign decel_stop    = (state == LMCD_DECEL);
    assign sleep_mode    = (state == LMCD_SLEEP);
    assign stopped_state = (state == LMCD_STOPPED);

    // only a power-on reset ends the observation
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bemf_active <= 1'b0;
        else if (cmd_bemf)
            bemf_active <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            switch_input_pin_o  <= 1'b0;
            switch_input_pin_oe <= 1'b0;
            switch_state        <= 1'b0;
        end
        else
        begin
            switch_input_pin_o  <= bemf_active && bemf_integrator;
            switch_input_pin_oe <= bemf_active;
            if (!bemf_active)
                switch_state    <= swi_sync;
        end
    end

    // apb slave: zero wait states, read data captured in the setup cycle
    assign pready  = 1'b1;
    assign apb_map = (paddr == LMCD_CTRL_OFS) || (paddr == LMCD_IDS_OFS)
                  || (paddr == LMCD_SECURE_POSITION_OFS) || (paddr == LMCD_STATUS_OFS)
                  || (paddr == LMCD_PARAM_OFS);
    assign pslverr = psel && penable && !apb_map;
    assign apb_wr  = psel && penable && pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg        <= LMCD_CTRL_RST;
            ids_reg         <= LMCD_IDS_RST;
            secure_position <= LMCD_SECURE_POSITION_DIS;
        end
        else if (apb_wr)
        begin
            case (paddr)
                LMCD_CTRL_OFS:   ctrl_reg        <= {17'h0, pwdata[14:8], 5'h0, pwdata[2:0]};
                LMCD_IDS_OFS:    ids_reg         <= {10'h0, pwdata[21:16], 2'h0,
                                                     pwdata[13:8], 2'h0, pwdata[5:0]};
                LMCD_SECURE_POSITION_OFS: secure_position <= pwdata[10:0];
                default:         ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            case (paddr)
                LMCD_CTRL_OFS:   prdata <= ctrl_reg;
                LMCD_IDS_OFS:    prdata <= ids_reg;
                LMCD_SECURE_POSITION_OFS: prdata <= {21'h0, secure_position};
                LMCD_STATUS_OFS: prdata <= {11'h0, switch_state, decel_stop, stopped_state,
                                            sleep_mode, bemf_active, target_position};
                LMCD_PARAM_OFS:  prdata <= {16'h0, max_velocity, min_velocity,
                                            absolute_threshold, acceleration};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_stop_start;
        (state == LMCD_RUN) && cmd_stop && motor_moving && !cmd_sleep;
    endsequence

    sequence s_halt;
        decel_stop && !motor_moving;
    endsequence

    a_short_load: assert property (
        accept_pos && short_hit && short_any && !halt_done
        |=> target_load && (target_position == $past(next_short_pos)))
        else $error("short frame entry not loaded as target");

    a_short_mode: assert property (
        (state == LMCD_RUN) && frm_valid && (step_resolution != LMCD_STEP_HALF)
        && (fid == short_id) && !param_hit && !cmd_sleep
        |=> !target_load)
        else $error("short frame acted on outside half-step");

    a_param_load: assert property (
        accept_pos && param_hit && !halt_done
        |=> (target_position == {$past(d[1]), $past(d[2])})
            && (max_velocity == $past(d[3][7:4])) && (acceleration == $past(d[4][3:0])))
        else $error("parameter frame fields not taken");

    a_stop_hold: assert property (
        s_stop_start ##1 (decel_stop throughout (motor_moving [*2])) ##1 s_halt
        |=> target_load && (target_position == $past(actual_position)) && !decel_stop)
        else $error("stop did not hold actual position");

    a_stop_ignored: assert property (
        (state == LMCD_RUN) && gp2_hit && (d[1][6:0] == LMCD_CMD_STOP)
        && two_stage_reference_run && !therm_rise
        |=> !decel_stop)
        else $error("stop taken during reference run");

    a_therm_stop: assert property (
        $rose(therm_sync) && (state == LMCD_RUN) && motor_moving && !cmd_sleep
        |=> decel_stop)
        else $error("thermal shutdown did not stop");

    a_sleep_secure_position: assert property (
        (state == LMCD_RUN) && cmd_sleep && motor_moving && secure_position_on
        |=> (target_position == {{5{$past(secure_position[10])}}, $past(secure_position)})
            && !decel_stop)
        else $error("sleep did not take secure position");

    a_sleep_permit: assert property (
        $rose(sleep_mode) |-> $past(sleep_permit))
        else $error("sleep entered without permit");

    a_bemf_sticky: assert property (
        bemf_active |=> bemf_active && $stable(switch_state))
        else $error("back-emf observation ended or switch sampled");

    a_bad_frame: assert property (
        (state == LMCD_RUN) && frm_valid && !frm_csum_ok |=> !target_load)
        else $error("corrupt frame changed the target");
endmodule : lmcd_decoder

// ==== lmcd_master_model.sv ====
// bus master side: presents received frames to the decoder
`timescale 1ns/1ps
module lmcd_master_model
(
    input  wire logic pclk,
    output logic        frm_valid,
    output logic [7:0]  frm_pid,
    output logic [3:0]  frm_len,
    output logic [63:0] frm_data,
    output logic        frm_csum_ok
);
    initial
    begin
        frm_valid   = 1'b0;
        frm_pid     = 8'h00;
        frm_len     = 4'h0;
        frm_data    = 64'h0;
        frm_csum_ok = 1'b0;
    end

    // one frame per call, valid for a single cycle
    task automatic send(input logic [5:0] id, input logic [3:0] len, input logic [63:0] d,
                        input logic ok);
        @(posedge pclk);
        frm_valid   <= 1'b1;
        frm_pid     <= {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
        frm_len     <= len;
        frm_data    <= d;
        frm_csum_ok <= ok;
        @(posedge pclk);
        frm_valid   <= 1'b0;
        // idle lines must not look like the last frame
        frm_data    <= ~d;
    endtask : send
endmodule : lmcd_master_model

// ==== tb_lin_motion_command_decoder.sv ====
// self-checking bench for the motion command decoder
`timescale 1ns/1ps
module tb_lin_motion_command_decoder;
    import lmcd_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, frm_valid, frm_csum_ok;
    logic        motor_moving, two_stage_reference_run, thermal_shutdown, bemf_integrator;
    logic        switch_input_pin_i, switch_input_pin_o, switch_input_pin_oe, target_load;
    logic        decel_stop, sleep_mode, stopped_state, bemf_active, switch_state;
    logic [7:0]  paddr, frm_pid;
    logic [31:0] pwdata, prdata;
    logic [3:0]  frm_len, max_velocity, min_velocity, absolute_threshold, acceleration;
    logic [63:0] frm_data, d;
    logic [15:0] actual_position, target_position, p;
    logic [10:0] s;
    logic [32:0] exp_rd[$];
    logic [15:0] exp_tgt[$];
    int          miscompares, total_checks, cycles;

    lmcd_decoder #(.ENTRIES(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .frm_valid, .frm_pid, .frm_len, .frm_data,
        .frm_csum_ok, .motor_moving, .actual_position, .two_stage_reference_run,
        .thermal_shutdown, .bemf_integrator, .switch_input_pin_i, .switch_input_pin_o,
        .switch_input_pin_oe, .target_position, .target_load, .max_velocity, .min_velocity,
        .absolute_threshold, .acceleration, .decel_stop, .sleep_mode, .stopped_state,
        .bemf_active, .switch_state);
    lmcd_master_model i_master (.pclk, .frm_valid, .frm_pid, .frm_len, .frm_data, .frm_csum_ok);

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // motor comes to rest; target must take the resting position
    task automatic halt;
        p = 16'($urandom);
        exp_tgt.push_back(p);
        // two more moving cycles so the stop sequence runs its full shape
        repeat (2) @(posedge pclk);
        motor_moving    <= 1'b0;
        actual_position <= p;
        repeat (2) @(posedge pclk);
        chk(decel_stop, 1'b0);
    endtask : halt

    task automatic param_frame;
        p = 16'($urandom);
        d = 64'($urandom);
        exp_tgt.push_back(p);
        i_master.send(6'h26, LMCD_LEN_PARAM, {32'h0, d[15:0], p[7:0], p[15:8]}, 1'b1);
        #1;
        chk({max_velocity, min_velocity, absolute_threshold, acceleration}, {d[7:0], d[15:8]});
    endtask : param_frame

    // result watcher: oldest note is compared with each result
    always @(posedge pclk)
    begin
        if (psel && penable && !pwrite)
            chk({pslverr, prdata}, exp_rd.pop_front());
        if (target_load === 1'b1)
            chk(target_position, exp_tgt.size() ? 33'(exp_tgt.pop_front()) : 33'h1_0000_0000);
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            stop_test();
        end
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {motor_moving, two_stage_reference_run, thermal_shutdown} = '0;
        {bemf_integrator, switch_input_pin_i, actual_position} = '0;
        presetn = 1'b0;
        p = 16'($urandom(32'h1D52));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(LMCD_CTRL_OFS, {1'b0, LMCD_CTRL_RST});
        rd(LMCD_SECURE_POSITION_OFS, {22'h0, LMCD_SECURE_POSITION_DIS});
        rd(8'h40, 33'h1_0000_0000);
        apb(1'b1, LMCD_CTRL_OFS, 32'h0000_0501);
        apb(1'b1, LMCD_IDS_OFS, 32'h000A_2635);
        rd(LMCD_IDS_OFS, 33'h0_000A_2635);
        $display("test registers done");
        s = 11'($urandom);
        p = 16'($urandom);
        d = {p[7:0], p[10:8], 5'h15, s[7:0], s[10:8], 5'h15, 16'hFFF4, 16'h0016};
        i_master.send(6'h35, LMCD_LEN_SHORT, d, 1'b0);
        i_master.send(6'h15, LMCD_LEN_SHORT, d, 1'b1);
        exp_tgt.push_back({{5{s[10]}}, s});
        i_master.send(6'h35, LMCD_LEN_SHORT, d, 1'b1);
        apb(1'b1, LMCD_CTRL_OFS, 32'h0000_0503);
        i_master.send(6'h35, LMCD_LEN_SHORT, d, 1'b1);
        apb(1'b1, LMCD_CTRL_OFS, 32'h0000_0501);
        param_frame();
        $display("test positioning done");
        d = {48'h0, 1'b0, 7'h03, 1'b1, LMCD_CMD_STOP};
        @(posedge pclk);
        motor_moving            <= 1'b1;
        two_stage_reference_run <= 1'b1;
        i_master.send(6'h0A, LMCD_LEN_GP2, d, 1'b1);
        #1;
        chk(decel_stop, 1'b0);
        @(posedge pclk);
        two_stage_reference_run <= 1'b0;
        i_master.send(6'h0A, LMCD_LEN_GP2, d, 1'b1);
        #1;
        chk(decel_stop, 1'b1);
        halt();
        motor_moving     <= 1'b1;
        thermal_shutdown <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(decel_stop, 1'b1);
        halt();
        thermal_shutdown <= 1'b0;
        $display("test stop done");
        s = {1'b1, 10'($urandom) | 10'h001};
        apb(1'b1, LMCD_SECURE_POSITION_OFS, {21'h0, s});
        motor_moving <= 1'b1;
        exp_tgt.push_back({{5{s[10]}}, s});
        i_master.send(6'h3C, LMCD_LEN_SLEEP, {{7{LMCD_FILL_BYTE}}, LMCD_SLEEP_D1}, 1'b1);
        @(posedge pclk);
        motor_moving <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({sleep_mode, stopped_state}, 2'b10);
        apb(1'b1, LMCD_CTRL_OFS, 32'h0000_0500);
        apb(1'b1, LMCD_SECURE_POSITION_OFS, {21'h0, LMCD_SECURE_POSITION_DIS});
        param_frame();
        @(posedge pclk);
        motor_moving <= 1'b1;
        i_master.send(6'h3C, LMCD_LEN_SLEEP, {{7{LMCD_FILL_BYTE}}, LMCD_SLEEP_D1}, 1'b1);
        #1;
        chk(decel_stop, 1'b1);
        halt();
        repeat (2) @(posedge pclk);
        chk({sleep_mode, stopped_state}, 2'b01);
        $display("test sleep done");
        i_master.send(6'h0A, LMCD_LEN_GP2, {48'h0, 8'h86, 1'b1, LMCD_CMD_BEMF}, 1'b1);
        #1;
        chk(bemf_active, 1'b0);
        i_master.send(6'h0A, LMCD_LEN_GP2, {48'h0, 8'h03, 1'b1, LMCD_CMD_BEMF}, 1'b1);
        repeat (2) @(posedge pclk);
        chk({bemf_active, switch_input_pin_oe}, 2'b11);
        bemf_integrator    <= 1'b1;
        switch_input_pin_i <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({switch_input_pin_o, switch_state}, 2'b10);
        i_master.send(6'h0A, LMCD_LEN_GP2, {48'h0, 8'h03, 1'b1, LMCD_CMD_STOP}, 1'b1);
        #1;
        chk(bemf_active, 1'b1);
        $display("test back emf done");
        repeat (3) @(posedge pclk);
        chk(33'(exp_tgt.size()), 33'h0);
        stop_test();
    end
endmodule : tb_lin_motion_command_decoder
